//--- rtl/serial_slave_pkg.sv
// Shared constants and types for the serial slave with EEPROM pass-through
package serial_slave_pkg;
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam int DEV_NUM_W = 2;
    localparam int READ_ADDR_W = 6;
    localparam int WRITE_ADDR_W = 8;
    localparam int CMD_DEV_LSB = 4;
    localparam int CMD_DEV_MSB = 5;
    localparam logic [1:0] CMD_TOP_ZERO = 2'h0;
    localparam logic [3:0] OP_READ = 4'h3;
    localparam logic [3:0] OP_WRITE = 4'h2;
    localparam logic [3:0] OP_STATUS = 4'h5;
    localparam logic [3:0] OP_PASS_ENTER = 4'h6;
    localparam logic [3:0] OP_PASS_EXIT = 4'h4;
    localparam logic [7:0] LOW_HOLE_LAST = 8'h03;
    localparam logic [7:0] TOP_HOLE_FIRST = 8'h38;
    localparam logic [7:0] TOP_HOLE_LAST = 8'h3F;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] STATUS_SELF = 8'h70;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    typedef enum logic [2:0] {
        PH_CMD, PH_RADDR, PH_RDATA, PH_WADDR, PH_WDATA, PH_STATUS, PH_IDLE
    } phase_t;

    // True for addresses that hold no register
    function automatic logic hole_addr(input logic [7:0] a);
        return (a <= LOW_HOLE_LAST) || ((a >= TOP_HOLE_FIRST) && (a <= TOP_HOLE_LAST));
    endfunction
endpackage

//--- rtl/serial_byte_if.sv
// Byte events and transmit loads between shifter and controller
`timescale 1ns/1ps
interface serial_byte_if;
    logic frame_start;
    logic frame_end;
    logic byte_valid;
    logic [7:0] byte_data;
    logic byte_load;
    logic [7:0] load_data;
    logic sck_fall;
    logic frame_active;

    modport shifter (
        output frame_start, frame_end, byte_valid, byte_data, sck_fall, frame_active,
        input byte_load, load_data
    );
    modport ctrl (
        input frame_start, frame_end, byte_valid, byte_data, sck_fall, frame_active,
        output byte_load, load_data
    );
endinterface

//--- rtl/serial_shifter.sv
// Pin synchroniser and bit shifter for the serial link
`timescale 1ns/1ps
module serial_shifter
    import serial_slave_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic sel_n_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    serial_byte_if.shifter bus
);
    logic [1:0] sel_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic sel_d_reg;
    logic sck_d_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [BYTE_W-1:0] rx_reg;
    logic [BYTE_W-1:0] tx_reg;
    logic rise;
    logic active;

    // ---------------------------------------------
    // Two-stage input synchronisers
    // ---------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sel_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h3;
            sdi_sync_reg <= 2'h0;
            sel_d_reg <= 1'b1;
            sck_d_reg <= 1'b1;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], sel_n_i};
            sck_sync_reg <= {sck_sync_reg[0], sck_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
            sel_d_reg <= sel_sync_reg[1];
            sck_d_reg <= sck_sync_reg[1];
        end
    end

    assign active = ~sel_sync_reg[1];
    assign rise = active && sck_sync_reg[1] && !sck_d_reg;
    assign bus.frame_active = active;
    assign bus.frame_start = sel_d_reg && !sel_sync_reg[1];
    assign bus.frame_end = !sel_d_reg && sel_sync_reg[1];
    assign bus.sck_fall = active && !sck_sync_reg[1] && sck_d_reg;

    // ---------------------------------------------
    // Receive on rising clock edges
    // ---------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt_reg <= BIT_FIRST;
            rx_reg <= ZERO_BYTE;
            bus.byte_valid <= 1'b0;
            bus.byte_data <= ZERO_BYTE;
        end else begin
            bus.byte_valid <= 1'b0;
            if (!active) begin
                bit_cnt_reg <= BIT_FIRST;
            end else if (rise) begin
                rx_reg <= {rx_reg[BYTE_W-2:0], sdi_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == BIT_LAST) begin
                    bus.byte_valid <= 1'b1;
                    bus.byte_data <= {rx_reg[BYTE_W-2:0], sdi_sync_reg[1]};
                end
            end
        end
    end

    // ---------------------------------------------
    // Transmit on falling clock edges, MSB first
    // ---------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            tx_reg <= ZERO_BYTE;
            sdo_o <= 1'b0;
        end else if (!active) begin
            sdo_o <= 1'b0;
        end else if (bus.sck_fall) begin
            if (bus.byte_load) begin
                sdo_o <= bus.load_data[BYTE_W-1];
                tx_reg <= {bus.load_data[BYTE_W-2:0], 1'b0};
            end else begin
                sdo_o <= tx_reg[BYTE_W-1];
                tx_reg <= {tx_reg[BYTE_W-2:0], 1'b0};
            end
        end
    end
endmodule

//--- rtl/serial_slave_eeprom_passthrough.sv
// Serial slave front end with burst register access and EEPROM pass-through
`timescale 1ns/1ps
module serial_slave_eeprom_passthrough
    import serial_slave_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic standalone_i,
    input wire logic device_number_pin_low_i,
    input wire logic device_number_pin_high_i,
    input wire logic sel_n_i,
    input wire logic sck_i,
    input wire logic sdi_pin_i,
    output logic sdi_pin_o,
    output logic sdi_pin_oe_n_o,
    input wire logic sdo_pin_i,
    output logic sdo_pin_o,
    output logic sdo_pin_oe_n_o,
    output logic eeprom_select_out_o,
    input wire logic [7:0] reg_rdata_i,
    output logic [5:0] reg_raddr_o,
    output logic reg_we_o,
    output logic [7:0] reg_waddr_o,
    output logic [7:0] reg_wdata_o
);
    serial_byte_if bus();

    logic [1:0] mode_sync_reg;
    logic [1:0] dev_lo_sync_reg;
    logic [1:0] dev_hi_sync_reg;
    logic standalone;
    logic data_in;
    logic shift_out;
    phase_t phase_reg;
    phase_t phase_next;
    logic pass_reg;
    logic pass_fwd_reg;
    logic [READ_ADDR_W-1:0] raddr_reg;
    logic [WRITE_ADDR_W-1:0] waddr_reg;
    logic [BYTE_W-1:0] cmd;
    logic addressed;
    logic drive_out;
    logic load_pending_reg;
    logic [BYTE_W-1:0] load_byte_reg;

    // ---------------------------------------------
    // Strap synchronisers
    // ---------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_sync_reg <= 2'h0;
            dev_lo_sync_reg <= 2'h0;
            dev_hi_sync_reg <= 2'h0;
        end else begin
            mode_sync_reg <= {mode_sync_reg[0], standalone_i};
            dev_lo_sync_reg <= {dev_lo_sync_reg[0], device_number_pin_low_i};
            dev_hi_sync_reg <= {dev_hi_sync_reg[0], device_number_pin_high_i};
        end
    end
    assign standalone = mode_sync_reg[1];

    // Stand-alone swaps which pin carries incoming and outgoing data
    assign data_in = standalone ? sdo_pin_i : sdi_pin_i;

    serial_shifter u_shifter (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .sel_n_i(sel_n_i),
        .sck_i(sck_i),
        .sdi_i(data_in),
        .sdo_o(shift_out),
        .bus(bus.shifter)
    );

    // ---------------------------------------------
    // Command decode
    // ---------------------------------------------
    assign cmd = bus.byte_data;

    // Command byte is ours: top bits clear and device number matched
    function automatic logic cmd_accepted(input logic [BYTE_W-1:0] c, input logic match);
        return match && (c[7:6] == CMD_TOP_ZERO);
    endfunction

    // Pins only steer addressing in CPU connection mode
    always_comb begin
        addressed = 1'b1;
        if (!standalone) begin
            addressed = (cmd[CMD_DEV_MSB:CMD_DEV_LSB] ==
                         {dev_hi_sync_reg[1], dev_lo_sync_reg[1]});
        end
    end

    always_comb begin
        phase_next = phase_reg;
        if (bus.frame_start) begin
            phase_next = PH_CMD;
        end else if (bus.byte_valid) begin
            case (phase_reg)
                PH_CMD: begin
                    phase_next = PH_IDLE;
                    // Pass-through hides every command but pass-exit from this device
                    if (!pass_reg && cmd_accepted(cmd, addressed)) begin
                        case (cmd[3:0])
                            OP_READ: phase_next = PH_RADDR;
                            OP_WRITE: phase_next = PH_WADDR;
                            OP_STATUS: phase_next = PH_STATUS;
                            default: phase_next = PH_IDLE;
                        endcase
                    end
                end
                PH_RADDR: phase_next = PH_RDATA;
                PH_WADDR: phase_next = PH_WDATA;
                PH_STATUS: phase_next = PH_IDLE;
                default: phase_next = phase_reg;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            phase_reg <= PH_IDLE;
        end else if (bus.frame_end) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // ---------------------------------------------
    // Pass-through mode
    // ---------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pass_reg <= 1'b0;
        end else if (bus.byte_valid && phase_reg == PH_CMD && cmd_accepted(cmd, addressed)) begin
            if (!pass_reg && cmd[3:0] == OP_PASS_ENTER) begin
                pass_reg <= 1'b1;
            end else if (pass_reg && cmd[3:0] == OP_PASS_EXIT) begin
                pass_reg <= 1'b0;
            end
        end
    end

    // Forwarding starts with the next frame so the entry frame stays private
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pass_fwd_reg <= 1'b0;
        end else if (!pass_reg) begin
            pass_fwd_reg <= 1'b0;
        end else if (!bus.frame_active) begin
            pass_fwd_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            eeprom_select_out_o <= 1'b1;
        end else if (pass_fwd_reg && pass_reg) begin
            eeprom_select_out_o <= !bus.frame_active;
        end else begin
            eeprom_select_out_o <= 1'b1;
        end
    end

    // ---------------------------------------------
    // Read address and transmit load
    // ---------------------------------------------
    assign reg_raddr_o = raddr_reg;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            raddr_reg <= '0;
            load_pending_reg <= 1'b0;
            load_byte_reg <= ZERO_BYTE;
        end else begin
            // A burst cut by select must not leak its byte into the next frame
            if (!bus.frame_active) begin
                load_pending_reg <= 1'b0;
            end else if (bus.sck_fall && load_pending_reg) begin
                load_pending_reg <= 1'b0;
            end
            if (bus.byte_valid && phase_next == PH_STATUS) begin
                load_pending_reg <= 1'b1;
                load_byte_reg <= STATUS_SELF;
            end else if (bus.byte_valid && phase_next == PH_RDATA) begin
                if (phase_reg == PH_RADDR) begin
                    raddr_reg <= cmd[READ_ADDR_W-1:0];
                end else begin
                    raddr_reg <= raddr_reg + 6'h01;
                end
                load_pending_reg <= 1'b1;
            end
            if (phase_reg == PH_RDATA && load_pending_reg) begin
                // Upper address bits never reach the map, so only the low range matters
                load_byte_reg <= hole_addr({2'h0, raddr_reg}) ? ZERO_BYTE
                                                               : reg_rdata_i;
            end
        end
    end

    assign bus.byte_load = load_pending_reg;
    assign bus.load_data = load_byte_reg;

    // ---------------------------------------------
    // Write address and strobes
    // ---------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            waddr_reg <= '0;
            reg_we_o <= 1'b0;
            reg_waddr_o <= ZERO_BYTE;
            reg_wdata_o <= ZERO_BYTE;
        end else begin
            reg_we_o <= 1'b0;
            if (bus.byte_valid && phase_reg == PH_WADDR) begin
                waddr_reg <= cmd;
            end else if (bus.byte_valid && phase_reg == PH_WDATA) begin
                waddr_reg <= waddr_reg + 8'h01;
                reg_we_o <= !hole_addr(waddr_reg);
                reg_waddr_o <= waddr_reg;
                reg_wdata_o <= cmd;
            end
        end
    end

    // ---------------------------------------------
    // Data pin drive
    // ---------------------------------------------
    assign drive_out = bus.frame_active && !pass_reg
                       && (phase_reg == PH_RDATA || phase_reg == PH_STATUS
                           || (phase_reg == PH_IDLE && load_pending_reg));

    always_comb begin
        sdo_pin_o = 1'b0;
        sdo_pin_oe_n_o = 1'b1;
        sdi_pin_o = 1'b0;
        sdi_pin_oe_n_o = 1'b1;
        if (standalone) begin
            sdi_pin_o = shift_out;
            sdi_pin_oe_n_o = !drive_out;
        end else begin
            sdo_pin_o = shift_out;
            sdo_pin_oe_n_o = !drive_out;
        end
    end
endmodule

//--- dv/serial_slave_chk.sv
// Pin-level assertions for the serial slave with EEPROM pass-through
`timescale 1ns/1ps
module serial_slave_chk (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic standalone_i,
    input wire logic sel_n_i,
    input wire logic sck_i,
    input wire logic sdi_pin_oe_n_o,
    input wire logic sdo_pin_o,
    input wire logic sdo_pin_oe_n_o,
    input wire logic eeprom_select_out_o,
    input wire logic reg_we_o,
    input wire logic [7:0] reg_waddr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    chk_we_single: assert property (reg_we_o |=> !reg_we_o)
        else $error("write strobe longer than one cycle");
    chk_we_no_hole: assert property (reg_we_o |-> !(reg_waddr_o < 8'h04 ||
        (reg_waddr_o > 8'h37 && reg_waddr_o < 8'h40))) else $error("write to hole");
    chk_we_in_frame: assert property (sel_n_i [*8] |-> !reg_we_o)
        else $error("write strobe outside a frame");
    chk_sdo_idle: assert property ((sel_n_i && !standalone_i) [*6] |-> sdo_pin_oe_n_o)
        else $error("data out driven with select high");
    chk_quiet_frame_start: assert property ($fell(sel_n_i) |->
        (sdo_pin_oe_n_o && sdi_pin_oe_n_o) [*8])
        else $error("data pin driven during command byte");
    chk_cpu_sdi_in: assert property (!standalone_i [*5] |-> sdi_pin_oe_n_o)
        else $error("data in pin driven in cpu mode");
    chk_sa_sdo_in: assert property (standalone_i [*5] |-> sdo_pin_oe_n_o)
        else $error("data out pin driven in stand-alone mode");
    chk_sdo_on_fall: assert property ($changed(sdo_pin_o) && !sdo_pin_oe_n_o |-> !sck_i)
        else $error("read data changed while clock high");
    chk_ee_follow: assert property (!eeprom_select_out_o |->
        !$past(sel_n_i, 3) || !$past(sel_n_i, 4) || !$past(sel_n_i, 5))
        else $error("eeprom select low without incoming select");
    chk_ee_release: assert property ($rose(sel_n_i) |-> ##[1:6] eeprom_select_out_o)
        else $error("eeprom select not released");

    cover property (reg_we_o);
    cover property (!eeprom_select_out_o);
    cover property (!sdo_pin_oe_n_o && sck_i);
endmodule

bind serial_slave_eeprom_passthrough serial_slave_chk u_chk (
    .clock_i(clock_i), .reset_i(reset_i), .standalone_i(standalone_i),
    .sel_n_i(sel_n_i), .sck_i(sck_i), .sdi_pin_oe_n_o(sdi_pin_oe_n_o),
    .sdo_pin_o(sdo_pin_o), .sdo_pin_oe_n_o(sdo_pin_oe_n_o),
    .eeprom_select_out_o(eeprom_select_out_o), .reg_we_o(reg_we_o),
    .reg_waddr_o(reg_waddr_o)
);

//--- dv/serial_master_model.sv
// Behavioural serial master that frames and clocks transfers
`timescale 1ns/1ps
module serial_master_model (
    input wire logic miso_i,
    output logic sel_n_o = 1'b1,
    output logic sck_o = 1'b1,
    output logic mosi_o = 1'b0,
    output logic [7:0] rx_o = 8'h00,
    output logic rx_stb_o = 1'b0
);
    // Clock stands high between frames except for one pulse after select rises; phase unrelated to the system clock
    task automatic frame(input logic [7:0] tx[$], input int nrd);
        logic [7:0] r;
        sel_n_o = 1'b0;
        #100;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                sck_o = 1'b0;
                mosi_o = tx[i][b];
                #62.5;
                sck_o = 1'b1;
                r[b] = miso_i;
                #62.5;
            end
            if (i >= tx.size() - nrd) begin
                rx_o = r;
                rx_stb_o = 1'b1;
                #1 rx_stb_o = 1'b0;
            end
        end
        #100 sel_n_o = 1'b1;
        mosi_o = ~mosi_o;
        // One clock with select high before the next frame
        #100 sck_o = 1'b0;
        #62.5 sck_o = 1'b1;
        #200;
    endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the serial slave with EEPROM pass-through
`timescale 1ns/1ps
module tb_top
    import serial_slave_pkg::*;
;
    logic clock_i = 0, reset_i = 1, standalone_i = 0, pin_lo = 1, pin_hi = 0;
    logic [7:0] reg_rdata = 8'h00;
    logic [5:0] raddr;
    logic sdi_o, sdi_oe_n, sdo_o, sdo_oe_n, ee_sel, we, sel_n, sck, mosi, sdi_w, sdo_w;
    logic rx_stb, miso;
    logic [7:0] waddr, wdata, rx, q[$], rq[$];
    logic [15:0] wq[$];
    logic [7:0] bad[4] = '{8'h22, 8'h52, 8'h1A, 8'h23};
    int error_cnt = 0, checked = 0;

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) reg_rdata <= {raddr, 2'b11};
    assign sdi_w = sdi_oe_n ? mosi : sdi_o;
    assign sdo_w = sdo_oe_n ? mosi : sdo_o;
    // Released data line floats high through its pull-up, so an idle slave reads ones
    assign miso = standalone_i ? (sdi_oe_n ? 1'b1 : sdi_o) : (sdo_oe_n ? 1'b1 : sdo_o);

    serial_master_model u_m (.miso_i(miso), .sel_n_o(sel_n),
        .sck_o(sck), .mosi_o(mosi), .rx_o(rx), .rx_stb_o(rx_stb));

    serial_slave_eeprom_passthrough dut (.clock_i(clock_i), .reset_i(reset_i),
        .standalone_i(standalone_i), .device_number_pin_low_i(pin_lo),
        .device_number_pin_high_i(pin_hi), .sel_n_i(sel_n), .sck_i(sck),
        .sdi_pin_i(sdi_w), .sdi_pin_o(sdi_o), .sdi_pin_oe_n_o(sdi_oe_n),
        .sdo_pin_i(sdo_w), .sdo_pin_o(sdo_o), .sdo_pin_oe_n_o(sdo_oe_n),
        .eeprom_select_out_o(ee_sel), .reg_rdata_i(reg_rdata), .reg_raddr_o(raddr),
        .reg_we_o(we), .reg_waddr_o(waddr), .reg_wdata_o(wdata));

    // ----------------------------------------
    // Compare, holes and closing
    // ----------------------------------------
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic hole(input logic [7:0] a);
        return a < 8'h04 || (a > 8'h37 && a < 8'h40);
    endfunction

    // Samples the pins in the middle of the second byte
    task automatic frame_at(input int nrd, input logic [15:0] e);
        fork
            u_m.frame(q, nrd);
            #1500 cmp("pins_mid_frame", e, {ee_sel, sdi_oe_n, sdo_oe_n});
        join
    endtask

    // Empty queue yields unknown, so a stray result always mismatches
    always @(negedge clock_i) if (we === 1'b1)
        cmp("write", wq.size() ? wq.pop_front() : 16'hxxxx, {waddr, wdata});
    always @(posedge rx_stb)
        cmp("read_byte", rq.size() ? rq.pop_front() : 8'hxx, rx);

    initial begin
        #500_000;
        error_cnt++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] a, d;
        void'($urandom(37));
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        cmp("idle_pins", 16'h0007, {ee_sel, sdi_oe_n, sdo_oe_n});
        for (int k = 0; k < 3; k++) begin
            a = k == 0 ? 8'hFE : k == 1 ? 8'h36 : 8'h04 + 8'($urandom % 48);
            q = '{{4'h1, OP_WRITE}, a};
            for (int i = 0; i < 7; i++) begin
                d = 8'($urandom);
                q.push_back(d);
                if (!hole(a + 8'(i))) wq.push_back({a + 8'(i), d});
            end
            u_m.frame(q, 0);
            a = k == 0 ? 8'h3E : k == 1 ? 8'hC1 : 8'h04 + 8'($urandom % 52);
            q = '{{4'h1, OP_READ}, a};
            for (int i = 0; i < 7; i++) begin
                q.push_back(8'h00);
                d = a + 8'(i);
                rq.push_back(hole({2'b00, d[5:0]}) ? 8'h00 : {d[5:0], 2'b11});
            end
            u_m.frame(q, 7);
        end
        foreach (bad[k]) begin
            q = '{bad[k], 8'h10, 8'hA5};
            u_m.frame(q, 0);
        end
        q = '{{4'h1, OP_STATUS}, 8'h00};
        rq.push_back(STATUS_SELF);
        frame_at(1, 16'h0006);
        q = '{{4'h1, OP_PASS_ENTER}};
        u_m.frame(q, 0);
        u_m.frame(q, 0);
        q = '{{4'h1, OP_STATUS}, 8'h00, {4'h1, OP_WRITE}, 8'h10, 8'h5A};
        frame_at(0, 16'h0003);
        q = '{{4'h1, OP_WRITE}, 8'h00, 8'h10, 8'h5A};
        frame_at(0, 16'h0003);
        q = '{{4'h1, OP_PASS_EXIT}};
        u_m.frame(q, 0);
        q = '{{4'h1, OP_STATUS}, 8'h00};
        rq.push_back(STATUS_SELF);
        frame_at(1, 16'h0006);
        @(posedge clock_i);
        standalone_i <= 1'b1;
        pin_lo <= 1'b0;
        pin_hi <= 1'b1;
        repeat (8) @(posedge clock_i);
        q = '{{4'h3, OP_STATUS}, 8'h00};
        rq.push_back(STATUS_SELF);
        frame_at(1, 16'h0005);
        repeat (10) @(posedge clock_i);
        cmp("pending", 16'h0000, 16'(wq.size() + rq.size()));
        wrap_up();
    end
endmodule
